//--- design/rtcia_pkg.sv
// Purpose: Shared constants for the clock unit's indirect access port and timebase.
// Assumes: Byte-wide special function register bus, one system clock.
// Notes:   Internal addresses are four bits wide.
package rtcia_pkg;
  // ------------------------------------------------------------
  // Host register addresses and fields
  // ------------------------------------------------------------
  localparam logic [7:0] SFR_ADDR_REG  = 8'hAC;
  localparam logic [7:0] SFR_DATA_REG  = 8'hAD;
  localparam logic [7:0] ADDR_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam int         BUSY_BIT      = 7;
  localparam int         AUTO_READ_ENABLE_BIT    = 6;
  localparam int         UNUSED_BIT    = 5;
  localparam int         SHORT_BIT     = 4;
  localparam int         ADDR_MSB      = 3;
  // ------------------------------------------------------------
  // Internal register map
  // ------------------------------------------------------------
  localparam logic [3:0] IA_CAPTURE0   = 4'h0;
  localparam logic [3:0] IA_CAPTURE3   = 4'h3;
  localparam logic [3:0] IA_CONTROL    = 4'h4;
  localparam logic [3:0] IA_OSC_CTRL   = 4'h5;
  localparam logic [3:0] IA_LOAD_CAP   = 4'h6;
  localparam logic [3:0] IA_PIN_CTRL   = 4'h7;
  localparam logic [3:0] IA_ALARM0     = 4'h8;
  localparam logic [3:0] IA_ALARM3     = 4'hB;
  // Control register fields
  localparam int         CTL_POWER     = 7;
  localparam int         CTL_MISSCLK   = 6;
  localparam int         CTL_OSC_FAILURE_FLAG   = 5;
  localparam int         CTL_CAPTURE   = 1;
  localparam int         CTL_SET       = 0;
  // Oscillator control, load capacitor and pin control fields
  localparam int         OSC_GAIN      = 7;
  localparam int         OSC_CRYSTAL_MODE_SELECT     = 6;
  localparam int         OSC_BIAS2     = 5;
  localparam int         OSC_VALID     = 4;
  localparam int         OSC_LFO       = 3;
  localparam int         LCAP_READY    = 7;
  localparam int         PIN_SHORT     = 0;
  // ------------------------------------------------------------
  // Timing and timer
  // ------------------------------------------------------------
  localparam logic [2:0] STROBE_NORMAL = 3'h7;
  localparam logic [2:0] STROBE_SHORT  = 3'h6;
  localparam logic [2:0] CNT_ONE       = 3'h1;
  localparam logic [31:0] TICK_STEP    = 32'h0000_0001;
  localparam logic [31:0] LFO_STEP     = 32'h0000_0002;
  localparam logic [3:0] ADDR_STEP     = 4'h1;
  localparam int         SYNC_BITS     = 5;

  typedef enum logic {
    RTCIA_IDLE = 1'b0,
    RTCIA_XFER = 1'b1
  } rtcia_state_t;
endpackage

//--- design/rtcia_sync.sv
// Purpose: Two-stage synchroniser for a group of level inputs.
// Assumes: Each bit is independent; no bus coherence is kept.
// Notes:   Stage one feeds stage two only.
`timescale 1ns/1ps
module rtcia_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- design/rtcia_top.sv
// Purpose: Indirect access port and timebase selection of a low-power clock unit.
// Assumes: Host bus strobes are one-cycle pulses on sys_clk; oscillator pins are asynchronous.
// Notes:   Host writes arriving while a transfer is running are dropped.
`timescale 1ns/1ps
module rtcia_top (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       osc_clk_in,
  input  wire logic       lfo_clk_in,
  input  wire logic       clock_valid_in,
  input  wire logic       load_cap_ready_in,
  input  wire logic       osc_fail_in,
  output logic            osc_power_enable,
  output logic            crystal_mode_select,
  output logic            gain_control_enable,
  output logic            bias_double_enable,
  output logic            low_freq_osc_enable,
  output logic      [3:0] load_cap_config,
  output logic            pin_short_control,
  output logic            missing_clock_enable,
  output logic     [31:0] timer_value
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [rtcia_pkg::SYNC_BITS-1:0] pins_sync;
  logic                            osc_s;
  logic                            lfo_s;
  logic                            valid_s;
  logic                            ready_s;
  logic                            fail_s;
  logic                            tb_prev;

  rtcia_sync #(.WIDTH(rtcia_pkg::SYNC_BITS)) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in ({osc_clk_in, lfo_clk_in, clock_valid_in, load_cap_ready_in, osc_fail_in}),
    .sync_out (pins_sync)
  );

  assign {osc_s, lfo_s, valid_s, ready_s, fail_s} = pins_sync;

  // ------------------------------------------------------------
  // Host registers and transfer engine
  // ------------------------------------------------------------
  rtcia_pkg::rtcia_state_t state;
  logic       auto_read_enable;
  logic       short_strobe;
  logic [3:0] int_addr;
  logic [7:0] data_reg;
  logic       op_write;
  logic [2:0] count;
  logic       busy;
  logic       done;
  logic       addr_wr;
  logic       data_wr;
  logic       data_rd;
  logic       launch;
  logic       launch_write;
  logic       launch_short;
  logic       auto_range;
  logic [7:0] int_rdata;

  assign busy         = (state == rtcia_pkg::RTCIA_XFER);
  assign done         = busy && (count == rtcia_pkg::CNT_ONE);
  assign addr_wr      = sfr_wr && (sfr_addr == rtcia_pkg::SFR_ADDR_REG) && !busy;
  assign data_wr      = sfr_wr && (sfr_addr == rtcia_pkg::SFR_DATA_REG) && !busy;
  assign data_rd      = sfr_rd && (sfr_addr == rtcia_pkg::SFR_DATA_REG) && !busy;
  assign launch_write = data_wr;
  assign launch       = (addr_wr && sfr_wdata[rtcia_pkg::BUSY_BIT])
                      || launch_write
                      || (data_rd && auto_read_enable);
  assign launch_short = addr_wr ? sfr_wdata[rtcia_pkg::SHORT_BIT] : short_strobe;
  assign auto_range   = (int_addr <= rtcia_pkg::IA_CAPTURE3)
                      || ((int_addr >= rtcia_pkg::IA_ALARM0) && (int_addr <= rtcia_pkg::IA_ALARM3));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= rtcia_pkg::RTCIA_IDLE;
      count    <= '0;
      op_write <= 1'b0;
    end else if (launch) begin
      state    <= rtcia_pkg::RTCIA_XFER;
      count    <= launch_short ? rtcia_pkg::STROBE_SHORT : rtcia_pkg::STROBE_NORMAL;
      op_write <= launch_write;
    end else if (done) begin
      state <= rtcia_pkg::RTCIA_IDLE;
      count <= '0;
    end else if (busy) begin
      count <= count - rtcia_pkg::CNT_ONE;
    end
  end

  // Bit 5 has no storage, so it cannot read back anything but zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_read_enable <= rtcia_pkg::ADDR_RESET[rtcia_pkg::AUTO_READ_ENABLE_BIT];
      short_strobe     <= rtcia_pkg::ADDR_RESET[rtcia_pkg::SHORT_BIT];
      int_addr         <= rtcia_pkg::ADDR_RESET[rtcia_pkg::ADDR_MSB:0];
    end else if (addr_wr) begin
      auto_read_enable <= sfr_wdata[rtcia_pkg::AUTO_READ_ENABLE_BIT];
      short_strobe     <= sfr_wdata[rtcia_pkg::SHORT_BIT];
      int_addr         <= sfr_wdata[rtcia_pkg::ADDR_MSB:0];
    end else if (done && auto_range) begin
      int_addr <= int_addr + rtcia_pkg::ADDR_STEP;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg <= rtcia_pkg::DATA_RESET;
    end else if (data_wr) begin
      data_reg <= sfr_wdata;
    end else if (done && !op_write) begin
      data_reg <= int_rdata;
    end
  end

  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr_addr == rtcia_pkg::SFR_ADDR_REG) begin
      sfr_rdata = {busy, auto_read_enable, 1'b0, short_strobe, int_addr};
    end else if (sfr_addr == rtcia_pkg::SFR_DATA_REG) begin
      sfr_rdata = data_reg;
    end
  end

  // ------------------------------------------------------------
  // Internal clock registers
  // ------------------------------------------------------------
  logic [7:0]  capture [4];
  logic [7:0]  alarm   [4];
  logic        osc_fail_flag;
  logic        int_wr;
  logic        cap_req;
  logic        set_req;
  logic        tick;
  logic [31:0] timer_step;

  assign int_wr  = done && op_write;
  assign cap_req = int_wr && (int_addr == rtcia_pkg::IA_CONTROL) && data_reg[rtcia_pkg::CTL_CAPTURE];
  assign set_req = int_wr && (int_addr == rtcia_pkg::IA_CONTROL) && data_reg[rtcia_pkg::CTL_SET];

  always_comb begin
    int_rdata = 8'h00;
    if (int_addr <= rtcia_pkg::IA_CAPTURE3) begin
      int_rdata = capture[int_addr[1:0]];
    end else if ((int_addr >= rtcia_pkg::IA_ALARM0) && (int_addr <= rtcia_pkg::IA_ALARM3)) begin
      int_rdata = alarm[int_addr[1:0]];
    end else if (int_addr == rtcia_pkg::IA_CONTROL) begin
      int_rdata[rtcia_pkg::CTL_POWER]   = osc_power_enable;
      int_rdata[rtcia_pkg::CTL_MISSCLK] = missing_clock_enable;
      int_rdata[rtcia_pkg::CTL_OSC_FAILURE_FLAG] = osc_fail_flag;
    end else if (int_addr == rtcia_pkg::IA_OSC_CTRL) begin
      int_rdata[rtcia_pkg::OSC_GAIN]  = gain_control_enable;
      int_rdata[rtcia_pkg::OSC_CRYSTAL_MODE_SELECT] = crystal_mode_select;
      int_rdata[rtcia_pkg::OSC_BIAS2] = bias_double_enable;
      int_rdata[rtcia_pkg::OSC_VALID] = valid_s;
      int_rdata[rtcia_pkg::OSC_LFO]   = low_freq_osc_enable;
    end else if (int_addr == rtcia_pkg::IA_LOAD_CAP) begin
      int_rdata = {ready_s, 3'b000, load_cap_config};
    end else if (int_addr == rtcia_pkg::IA_PIN_CTRL) begin
      int_rdata[rtcia_pkg::PIN_SHORT] = pin_short_control;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_power_enable     <= 1'b0;
      missing_clock_enable <= 1'b0;
      gain_control_enable  <= 1'b0;
      crystal_mode_select  <= 1'b0;
      bias_double_enable   <= 1'b0;
      low_freq_osc_enable  <= 1'b0;
      load_cap_config      <= '0;
      pin_short_control    <= 1'b0;
    end else if (int_wr) begin
      if (int_addr == rtcia_pkg::IA_CONTROL) begin
        osc_power_enable     <= data_reg[rtcia_pkg::CTL_POWER];
        missing_clock_enable <= data_reg[rtcia_pkg::CTL_MISSCLK];
      end
      if (int_addr == rtcia_pkg::IA_OSC_CTRL) begin
        gain_control_enable <= data_reg[rtcia_pkg::OSC_GAIN];
        crystal_mode_select <= data_reg[rtcia_pkg::OSC_CRYSTAL_MODE_SELECT];
        bias_double_enable  <= data_reg[rtcia_pkg::OSC_BIAS2];
        low_freq_osc_enable <= data_reg[rtcia_pkg::OSC_LFO];
      end
      if (int_addr == rtcia_pkg::IA_LOAD_CAP) begin
        load_cap_config <= data_reg[3:0];
      end
      if (int_addr == rtcia_pkg::IA_PIN_CTRL) begin
        pin_short_control <= data_reg[rtcia_pkg::PIN_SHORT];
      end
    end
  end

  // Failure is sticky; a new failure beats a clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_fail_flag <= 1'b0;
    end else if (fail_s && missing_clock_enable) begin
      osc_fail_flag <= 1'b1;
    end else if (int_wr && (int_addr == rtcia_pkg::IA_CONTROL) && !data_reg[rtcia_pkg::CTL_OSC_FAILURE_FLAG]) begin
      osc_fail_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture <= '{default: 8'h00};
      alarm   <= '{default: 8'h00};
    end else if (cap_req) begin
      capture <= '{timer_value[7:0], timer_value[15:8], timer_value[23:16], timer_value[31:24]};
    end else if (int_wr && (int_addr <= rtcia_pkg::IA_CAPTURE3)) begin
      capture[int_addr[1:0]] <= data_reg;
    end else if (int_wr && (int_addr >= rtcia_pkg::IA_ALARM0) && (int_addr <= rtcia_pkg::IA_ALARM3)) begin
      alarm[int_addr[1:0]] <= data_reg;
    end
  end

  // ------------------------------------------------------------
  // Timebase selection and timer
  // ------------------------------------------------------------
  logic tb_sel;

  // No validity gating: an enabled source counts from its first edge
  assign tb_sel     = low_freq_osc_enable ? lfo_s : osc_s;
  assign tick       = tb_sel && !tb_prev && (low_freq_osc_enable || osc_power_enable);
  assign timer_step = low_freq_osc_enable ? rtcia_pkg::LFO_STEP : rtcia_pkg::TICK_STEP;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tb_prev <= 1'b0;
    end else begin
      tb_prev <= tb_sel;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_value <= '0;
    end else if (set_req) begin
      timer_value <= {capture[3], capture[2], capture[1], capture[0]};
    end else if (tick) begin
      timer_value <= timer_value + timer_step;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_busy_normal_len: assert property (@(posedge sys_clk) disable iff (!reset_n)
    launch && !launch_short |=> busy [*7] ##1 !busy) else $error("normal access not 7 cycles");
  a_busy_short_len: assert property (@(posedge sys_clk) disable iff (!reset_n)
    launch && launch_short |=> busy [*6] ##1 !busy) else $error("short access not 6 cycles");
  a_bit5_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sfr_addr == rtcia_pkg::SFR_ADDR_REG |-> !sfr_rdata[rtcia_pkg::UNUSED_BIT]) else $error("bit 5 not zero");
  a_busy_reads_back: assert property (@(posedge sys_clk) disable iff (!reset_n)
    addr_wr && sfr_wdata[rtcia_pkg::BUSY_BIT] |=> sfr_addr != rtcia_pkg::SFR_ADDR_REG
    || sfr_rdata[rtcia_pkg::BUSY_BIT]) else $error("busy not shown after read start");
  a_addr_incr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    done && auto_range |=> int_addr == 4'($past(int_addr) + rtcia_pkg::ADDR_STEP)) else $error("no increment");
  a_addr_keep: assert property (@(posedge sys_clk) disable iff (!reset_n)
    done && !auto_range |=> $stable(int_addr)) else $error("address moved");
  a_read_fetch: assert property (@(posedge sys_clk) disable iff (!reset_n)
    done && !op_write |=> data_reg == $past(int_rdata)) else $error("read byte not loaded");
  a_data_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !busy && !data_wr |=> $stable(data_reg)) else $error("data changed while idle");
  a_auto_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    data_rd && auto_read_enable |=> busy && !op_write) else $error("auto read not started");
  a_write_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
    data_wr && !short_strobe |=> busy && op_write ##6 int_wr) else $error("write not carried out");
  a_lfo_double: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick && !set_req && low_freq_osc_enable |=> timer_value == $past(timer_value) + rtcia_pkg::LFO_STEP)
    else $error("low frequency tick did not add two");

  // ------------------------------------------------------------
  // Further checks
  // ------------------------------------------------------------
  a_write_short: assert property (@(posedge sys_clk) disable iff (!reset_n)
    data_wr && short_strobe |=> busy && op_write ##5 int_wr) else $error("short write not carried out");
  a_idle_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !busy |-> count == '0) else $error("counter running while idle");
  a_cfg_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    busy |=> $stable({auto_read_enable, short_strobe})) else $error("address fields changed while busy");

  a_busy_view: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sfr_addr == rtcia_pkg::SFR_ADDR_REG |-> sfr_rdata[rtcia_pkg::BUSY_BIT] == busy) else $error("busy bit wrong");
  a_auto_taken: assert property (@(posedge sys_clk) disable iff (!reset_n)
    addr_wr |=> auto_read_enable == $past(sfr_wdata[rtcia_pkg::AUTO_READ_ENABLE_BIT])) else $error("auto read bit not taken");
  a_auto_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    data_rd && !auto_read_enable |=> !busy) else $error("read started with auto read off");
  a_short_taken: assert property (@(posedge sys_clk) disable iff (!reset_n)
    addr_wr |=> short_strobe == $past(sfr_wdata[rtcia_pkg::SHORT_BIT])) else $error("short bit not taken");
  a_data_taken: assert property (@(posedge sys_clk) disable iff (!reset_n)
    data_wr |=> data_reg == $past(sfr_wdata)) else $error("data byte not taken");

  // A failure seen in the clearing cycle must survive the clear
  a_fail_wins: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fail_s && missing_clock_enable |=> osc_fail_flag) else $error("oscillator failure lost");
  a_bias_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    int_wr && int_addr == rtcia_pkg::IA_OSC_CTRL |=> bias_double_enable == $past(data_reg[rtcia_pkg::OSC_BIAS2]))
    else $error("bias double not written");
  a_pin_short: assert property (@(posedge sys_clk) disable iff (!reset_n)
    int_wr && int_addr == rtcia_pkg::IA_PIN_CTRL |=> pin_short_control == $past(data_reg[rtcia_pkg::PIN_SHORT]))
    else $error("pin short not written");
  a_lfo_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    int_wr && int_addr == rtcia_pkg::IA_OSC_CTRL |=> low_freq_osc_enable == $past(data_reg[rtcia_pkg::OSC_LFO]))
    else $error("low frequency enable not written");

  a_osc_single: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick && !set_req && !low_freq_osc_enable |=> timer_value == $past(timer_value) + rtcia_pkg::TICK_STEP)
    else $error("oscillator tick did not add one");
  a_timer_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !tick && !set_req |=> $stable(timer_value)) else $error("timer moved without a tick");
endmodule

//--- bench/rtcia_host_model.sv
// Purpose: Processor-side model issuing special function register accesses.
// Assumes: One-cycle strobes launched just after a rising edge of sys_clk.
// Notes:   Idle bus shows an unmapped address and flipped data, never stale values.
`timescale 1ns/1ps
module rtcia_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] sfr_rdata,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata
);
  initial begin
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_wdata = 8'h00;
  end

  // ----------------------------------------
  // Accesses: plain stores and loads only, the data register is never read-modify-written
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    sfr_wr    = 1'b0;
    sfr_addr  = 8'h00;
    sfr_wdata = ~d;
  endtask

  // Caller sits just after an edge; the read strobe is taken at the next edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    #20;
    d = sfr_rdata;
    @(posedge sys_clk);
    #1;
    sfr_rd   = 1'b0;
    sfr_addr = 8'h00;
  endtask

  // Looks at the read mux without a strobe, so no side effect is caused
  task automatic peek(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    #20;
    d = sfr_rdata;
    @(posedge sys_clk);
    #1;
    sfr_addr = 8'h00;
  endtask
endmodule

//--- bench/test_rtcia_top.sv
// Purpose: Self-checking bench for the indirect access port and timebase.
// Assumes: Status inputs held low until the crystal start scenario drives them high; timebase pins toggled slowly against sys_clk.
// Notes:   Every expectation is worked out from the register layout, not the design.
`timescale 1ns/1ps
module test_rtcia_top;
  logic        sys_clk;
  logic        reset_n;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        osc_clk_in;
  logic        lfo_clk_in;
  logic        clock_valid_in;
  logic        load_cap_ready_in;
  logic        osc_fail_in;
  logic        osc_power_enable;
  logic        crystal_mode_select;
  logic        gain_control_enable;
  logic        bias_double_enable;
  logic        low_freq_osc_enable;
  logic [3:0]  load_cap_config;
  logic        pin_short_control;
  logic        missing_clock_enable;
  logic [31:0] timer_value;
  int          num_errors;
  int          check_count;

  rtcia_host_model u_host (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));

  rtcia_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .osc_clk_in(osc_clk_in),
    .lfo_clk_in(lfo_clk_in), .clock_valid_in(clock_valid_in), .load_cap_ready_in(load_cap_ready_in),
    .osc_fail_in(osc_fail_in), .osc_power_enable(osc_power_enable),
    .crystal_mode_select(crystal_mode_select), .gain_control_enable(gain_control_enable),
    .bias_double_enable(bias_double_enable), .low_freq_osc_enable(low_freq_osc_enable),
    .load_cap_config(load_cap_config), .pin_short_control(pin_short_control),
    .missing_clock_enable(missing_clock_enable), .timer_value(timer_value));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Counts busy cycles; a transfer that never ends stops the run
  task automatic wait_idle(output int n);
    logic [7:0] v;
    n = 0;
    repeat (30) begin
      u_host.peek(8'hAC, v);
      if (v[7] === 1'b0) return;
      n++;
    end
    num_errors++;
    $display("CHECK FAILED busy wait expected 0 seen 1");
    tally_and_finish();
  endtask

  task automatic wr_wait(input logic [7:0] a, input logic [7:0] d, input int exp_n);
    int n;
    u_host.wr(a, d);
    wait_idle(n);
    check("busy length", n, exp_n);
  endtask

  // Slow pulses on a timebase pin, wide enough for the two-stage synchroniser
  task automatic tick(input bit low_freq_osc, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (low_freq_osc) lfo_clk_in = 1'b1; else osc_clk_in = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      lfo_clk_in = 1'b0;
      osc_clk_in = 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  // Indirect read through the busy bit, then the fetched byte
  task automatic read_ind(input logic [3:0] r, output logic [7:0] v);
    wr_wait(8'hAC, {4'h9, r}, 6);
    u_host.peek(8'hAD, v);
  endtask

  // Polls one bit of an internal register; running out ends the run
  task automatic poll_bit(input logic [3:0] r, input int b, output logic [7:0] v);
    repeat (8) begin
      read_ind(r, v);
      if (v[b] === 1'b1) break;
    end
    check("poll bit", v[b], 1'b1);
    if (v[b] !== 1'b1) tally_and_finish();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] v;
    u_host.peek(8'hAC, v);
    check("address reg reset", v, 8'h00);
    u_host.peek(8'hAD, v);
    check("data reg reset", v, 8'h00);
    u_host.peek(8'hAE, v);
    check("unmapped read", v, 8'h00);
    check("timer reset", timer_value, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_write_read();
    logic [7:0] v;
    u_host.wr(8'hAC, 8'h06);
    wr_wait(8'hAD, 8'h0A, 7);
    check("load cap", load_cap_config, 4'hA);
    u_host.wr(8'hAC, 8'h07);
    wr_wait(8'hAD, 8'h00, 7);
    wr_wait(8'hAC, 8'h86, 7);
    u_host.rd(8'hAD, v);
    check("indirect read", v, 8'h0A);
    u_host.peek(8'hAC, v);
    check("no step on addr 6", v, 8'h06);
    $display("test write read done");
  endtask

  task automatic t_short_bits();
    logic [7:0] v;
    u_host.wr(8'hAC, 8'h37);
    u_host.peek(8'hAC, v);
    check("unused bit", v, 8'h17);
    wr_wait(8'hAD, 8'h01, 6);
    check("pin short", pin_short_control, 1'b1);
    $display("test short strobe done");
  endtask

  task automatic t_timebase();
    u_host.wr(8'hAC, 8'h15);
    wr_wait(8'hAD, 8'hE0, 6);
    check("osc bits", {gain_control_enable, crystal_mode_select, bias_double_enable}, 3'b111);
    wr_wait(8'hAD, 8'h00, 6);
    check("self osc bits", {crystal_mode_select, bias_double_enable}, 2'b00);
    u_host.wr(8'hAC, 8'h14);
    wr_wait(8'hAD, 8'h80, 6);
    check("power", osc_power_enable, 1'b1);
    tick(1'b0, 5);
    check("osc ticks", timer_value, 32'h0000_0005);
    u_host.wr(8'hAC, 8'h15);
    wr_wait(8'hAD, 8'h08, 6);
    check("lfo enable", low_freq_osc_enable, 1'b1);
    tick(1'b1, 4);
    check("lfo ticks", timer_value, 32'h0000_000D);
    tick(1'b0, 2);
    check("osc ignored", timer_value, 32'h0000_000D);
    $display("test timebase done");
  endtask

  task automatic t_capture_autoread();
    logic [7:0]  v;
    logic [31:0] t;
    int          n;
    t = timer_value;
    u_host.wr(8'hAC, 8'h14);
    wr_wait(8'hAD, 8'h82, 6);
    wr_wait(8'hAC, 8'hD0, 6);
    for (int i = 0; i < 4; i++) begin
      u_host.rd(8'hAD, v);
      check("capture byte", v, t[8*i +: 8]);
      wait_idle(n);
      check("auto read length", n, 6);
    end
    u_host.peek(8'hAD, v);
    check("control fetched", v, 8'h80);
    repeat (5) @(posedge sys_clk);
    #1;
    u_host.peek(8'hAD, v);
    check("data held", v, 8'h80);
    u_host.peek(8'hAC, v);
    check("addr after capture", v, 8'h54);
    $display("test capture autoread done");
  endtask

  task automatic t_alarm();
    logic [7:0] v;
    u_host.wr(8'hAC, 8'h18);
    for (int i = 0; i < 4; i++) wr_wait(8'hAD, 8'h10 + i[7:0], 6);
    u_host.peek(8'hAC, v);
    check("addr after alarm", v, 8'h1C);
    $display("test alarm done");
  endtask

  // Start-up waits are cut to a few cycles; the status pins stand in for the analog flags
  task automatic t_crystal_start();
    logic [7:0] v;
    u_host.wr(8'hAC, 8'h15);
    wr_wait(8'hAD, 8'h60, 6);
    u_host.wr(8'hAC, 8'h16);
    wr_wait(8'hAD, 8'h09, 6);
    u_host.wr(8'hAC, 8'h14);
    wr_wait(8'hAD, 8'h80, 6);
    read_ind(4'h5, v);
    check("valid low", v, 8'h60);
    repeat (20) @(posedge sys_clk);
    #1;
    clock_valid_in    = 1'b1;
    load_cap_ready_in = 1'b1;
    poll_bit(4'h5, 4, v);
    check("valid read", v, 8'h70);
    poll_bit(4'h6, 7, v);
    check("load cap ready", v, 8'h89);
    u_host.wr(8'hAC, 8'h15);
    wr_wait(8'hAD, 8'hC0, 6);
    check("run osc bits", {gain_control_enable, crystal_mode_select, bias_double_enable}, 3'b110);
    u_host.wr(8'hAC, 8'h14);
    wr_wait(8'hAD, 8'hC0, 6);
    check("missing clock on", missing_clock_enable, 1'b1);
    osc_fail_in = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    osc_fail_in = 1'b0;
    read_ind(4'h4, v);
    check("fail flag set", v, 8'hE0);
    wr_wait(8'hAD, 8'hC0, 6);
    read_ind(4'h4, v);
    check("fail flag cleared", v, 8'hC0);
    u_host.wr(8'hAC, 8'h15);
    wr_wait(8'hAD, 8'h20, 6);
    u_host.wr(8'hAC, 8'h16);
    wr_wait(8'hAD, 8'h03, 6);
    check("self osc trim", {crystal_mode_select, bias_double_enable, load_cap_config}, 6'h13);
    $display("test crystal start done");
  endtask

  initial begin
    num_errors        = 0;
    check_count       = 0;
    reset_n           = 1'b0;
    osc_clk_in        = 1'b0;
    lfo_clk_in        = 1'b0;
    clock_valid_in    = 1'b0;
    load_cap_ready_in = 1'b0;
    osc_fail_in       = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_write_read();
    t_short_bits();
    t_timebase();
    t_capture_autoread();
    t_alarm();
    t_crystal_start();
    tally_and_finish();
  end
endmodule
